// >>> hw/adc_ctrl_pkg.sv
// constants, types and register map of the converter control block
//
// Summary of operation
// - act only with enable high, select low
// - read_not_convert high reads, low starts conversion
// - short select low twelve bits, high eight
// - byte read: select low MSBs, high LSBs
// - word width high drives twelve bits together
// - low byte: four LSBs then four zeros
// - status high during conversion, low after
// - starts ignored while a conversion runs
// - data outputs stay off during conversion
// - start clears done flags; short set at 8, full at cycle end
package adc_ctrl_pkg;

  // =========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;   // system clock period
  localparam int BIT_TIME_NS   = 2500; // one approximation step
  localparam int BIT_CYCLES_I  = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [8:0] BIT_CYCLES = 9'(BIT_CYCLES_I);

  // =========================================================
  // conversion geometry
  localparam logic [3:0]  MSB_IDX   = 4'hB;   // first trial bit
  localparam logic [3:0]  SHORT_IDX = 4'h4;   // last bit of the short cycle
  localparam logic [3:0]  FULL_IDX  = 4'h0;   // last bit of the full cycle
  localparam logic [11:0] RESULT_RST = 12'h000;

  // =========================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_STATUS   = 8'h00;
  localparam logic [7:0] ADDR_RESULT   = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK = 8'h0C;

  // status register fields
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_SHORT_BIT = 1;
  localparam int ST_FULL_BIT  = 2;
  localparam int ST_WORD_BIT  = 3;
  localparam int ST_MODE_BIT  = 4;

  // interrupt event fields
  localparam int EV_DONE_BIT    = 0;
  localparam int EV_IGNORED_BIT = 1;
  localparam int EV_BLOCKED_BIT = 2;
  localparam logic [2:0] INT_STAT_RST = 3'h0;
  localparam logic [2:0] INT_MASK_RST = 3'h0;

  // =========================================================
  // types
  typedef enum logic {ST_IDLE, ST_CONV} conv_state_type;

  // pin group sampled from the processor side and the comparator
  typedef struct packed {
    logic enable;
    logic select_n;
    logic read_not_convert;
    logic byte_or_short_select;
    logic word_width_select;
    logic comp_ge;
  } pin_in_type;

  // 12-bit data lines with enables
  typedef struct packed {
    logic [11:0] data;
    logic [11:0] oe;
  } data_drive_type;

endpackage

// >>> hw/adc_bus_control.sv
// control logic of the successive-approximation converter
//
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module adc_bus_control
  import adc_ctrl_pkg::*;
(
  input  wire  logic        CLK_SYS,
  input  wire  logic        RESET,
  // processor pins
  input  wire  logic        ENABLE,
  input  wire  logic        SELECT_N,
  input  wire  logic        READ_NOT_CONVERT,
  input  wire  logic        BYTE_OR_SHORT_SELECT,
  input  wire  logic        WORD_WIDTH_SELECT,
  output var   logic [11:0] DATA_OUT,
  output var   logic [11:0] DATA_OE,
  output var   logic        CONVERSION_STATUS,
  // analog side
  input  wire  logic        COMP_GE,
  output var   logic [11:0] DAC_CODE,
  // register bus
  input  wire  logic        HSEL,
  input  wire  logic [31:0] HADDR,
  input  wire  logic [1:0]  HTRANS,
  input  wire  logic        HWRITE,
  input  wire  logic [2:0]  HSIZE,
  input  wire  logic [31:0] HWDATA,
  input  wire  logic        HREADY,
  output var   logic [31:0] HRDATA,
  output var   logic        HREADYOUT,
  output var   logic        HRESP,
  output var   logic        IRQ
);

  // =========================================================
  // functions

  // format the result for the data lines
  function automatic data_drive_type format_read(
    input logic [11:0] res,
    input logic        word_mode,
    input logic        low_byte
  );
    data_drive_type d;
    d = '{data: 12'h000, oe: 12'h000};
    if (word_mode) begin
      d.data = res;
      d.oe   = 12'hFFF;
    end else if (!low_byte) begin
      d.data = {res[11:4], 4'h0};
      d.oe   = 12'hFF0;
    end else begin
      d.data = {res[3:0], 4'h0, 4'h0};
      d.oe   = 12'hFF0;
    end
    return d;
  endfunction

  // sticky event update, a set beats a clear
  function automatic logic [2:0] sticky(
    input logic [2:0] cur,
    input logic [2:0] clr,
    input logic [2:0] set
  );
    return (cur & ~clr) | set;
  endfunction

  // =========================================================
  // pin synchronisers

  pin_in_type pin_raw;    // pins as they arrive
  pin_in_type pin_meta_r; // first stage, read by second only
  pin_in_type pin_r;      // synchronised pins

  assign pin_raw = '{enable:               ENABLE,
                     select_n:             SELECT_N,
                     read_not_convert:     READ_NOT_CONVERT,
                     byte_or_short_select: BYTE_OR_SHORT_SELECT,
                     word_width_select:    WORD_WIDTH_SELECT,
                     comp_ge:              COMP_GE};

  // two flops on every pin
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      pin_meta_r <= '{enable: 1'b0, select_n: 1'b1, read_not_convert: 1'b1,
                      byte_or_short_select: 1'b0, word_width_select: 1'b0,
                      comp_ge: 1'b0};
      pin_r      <= '{enable: 1'b0, select_n: 1'b1, read_not_convert: 1'b1,
                      byte_or_short_select: 1'b0, word_width_select: 1'b0,
                      comp_ge: 1'b0};
    end else begin
      pin_meta_r <= pin_raw;
      pin_r      <= pin_meta_r;
    end
  end

  // =========================================================
  // command decode

  logic chip_active; // enable and select together
  logic start_cond;  // convert command level
  logic read_cond;   // read command level
  logic start_d_r;   // previous convert level
  logic read_d_r;    // previous read level
  logic start_edge;  // new convert command
  logic read_edge;   // new read command

  assign chip_active = pin_r.enable && !pin_r.select_n;
  assign start_cond  = chip_active && !pin_r.read_not_convert;
  assign read_cond   = chip_active && pin_r.read_not_convert;
  assign start_edge  = start_cond && !start_d_r;
  assign read_edge   = read_cond && !read_d_r;

  // edge memory so one strobe starts one conversion
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      start_d_r <= 1'b0;
      read_d_r  <= 1'b0;
    end else begin
      start_d_r <= start_cond;
      read_d_r  <= read_cond;
    end
  end

  // =========================================================
  // conversion sequencer

  conv_state_type state_r;      // sequencer state
  logic [8:0]     cnt_r;        // cycles within one step
  logic [3:0]     idx_r;        // bit under trial
  logic [11:0]    sar_r;        // approximation register
  logic [11:0]    result_r;     // output latch
  logic           short_mode_r; // running an 8-bit cycle
  logic           short_done_r; // short portion finished
  logic           full_done_r;  // whole cycle finished
  logic           step_end;     // last cycle of a step
  logic           accept;       // start taken
  logic           conv_end;     // cycle finishes now

  assign step_end = (state_r == ST_CONV) && (cnt_r == BIT_CYCLES - 9'h001);
  assign accept   = start_edge && (state_r == ST_IDLE);
  assign conv_end = step_end &&
                    (idx_r == (short_mode_r ? SHORT_IDX : FULL_IDX));

  // state and step counter
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      state_r <= ST_IDLE;
      cnt_r   <= 9'h000;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          cnt_r <= 9'h000;
          if (accept) begin
            state_r <= ST_CONV;
          end
        end
        ST_CONV: begin
          cnt_r <= step_end ? 9'h000 : cnt_r + 9'h001;
          if (conv_end) begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // trial bits, kept or dropped by the comparator
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      sar_r        <= RESULT_RST;
      idx_r        <= MSB_IDX;
      short_mode_r <= 1'b0;
    end else if (accept) begin
      sar_r        <= 12'h800;
      idx_r        <= MSB_IDX;
      short_mode_r <= pin_r.byte_or_short_select;
    end else if (step_end) begin
      if (!pin_r.comp_ge) begin
        sar_r[idx_r] <= 1'b0;
      end
      if (!conv_end) begin
        idx_r                       <= idx_r - 4'h1;
        sar_r[4'(idx_r - 4'h1)]     <= 1'b1;
      end
    end
  end

  // done flags: both low at start, short set at 8 bits, full at the last bit of the cycle (8 or 12)
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      short_done_r <= 1'b1;
      full_done_r  <= 1'b1;
    end else if (accept) begin
      short_done_r <= 1'b0;
      full_done_r  <= 1'b0;
    end else if (step_end) begin
      if (idx_r == SHORT_IDX) begin
        short_done_r <= 1'b1;
      end
      if (conv_end) begin
        full_done_r <= 1'b1;
      end
    end
  end

  // result latch, only rewritten when a cycle completes
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      result_r <= RESULT_RST;
    end else if (conv_end) begin
      // the last step's decision folded in here
      result_r <= pin_r.comp_ge ? sar_r : (sar_r & ~(12'h001 << idx_r));
    end
  end

  // =========================================================
  // pin outputs

  data_drive_type rd_fmt; // formatted read data

  assign rd_fmt = format_read(result_r, pin_r.word_width_select,
                              pin_r.byte_or_short_select);

  // status line and data buffers
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      CONVERSION_STATUS <= 1'b0;
      DATA_OUT          <= 12'h000;
      DATA_OE           <= 12'h000;
      DAC_CODE          <= RESULT_RST;
    end else begin
      CONVERSION_STATUS <= (state_r == ST_CONV) || accept;
      DAC_CODE          <= sar_r;
      if (read_cond && state_r == ST_IDLE && !accept) begin
        DATA_OUT <= rd_fmt.data;
        DATA_OE  <= rd_fmt.oe;
      end else begin
        DATA_OUT <= 12'h000;
        DATA_OE  <= 12'h000;
      end
    end
  end

  // =========================================================
  // register bus slave

  logic       wr_pend_r;  // write data phase follows
  logic [7:0] wr_addr_r;  // latched write address
  logic [2:0] int_stat_r; // sticky events
  logic [2:0] int_mask_r; // event enables
  logic [2:0] ev_set;     // events this cycle
  logic [2:0] ev_clr;     // one-writes to the event register
  logic       addr_ok;    // valid address phase
  logic [31:0] rd_word;   // read mux

  assign addr_ok = HSEL && HREADY && HTRANS[1];
  assign ev_set  = {read_edge && (state_r == ST_CONV),
                    start_edge && (state_r == ST_CONV),
                    conv_end};
  assign ev_clr  = (wr_pend_r && wr_addr_r == ADDR_INT_STAT) ? HWDATA[2:0] : 3'h0;

  // read mux from the address phase
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (HADDR[7:0])
      ADDR_STATUS: begin
        rd_word[ST_BUSY_BIT]  = state_r == ST_CONV;
        rd_word[ST_SHORT_BIT] = short_done_r;
        rd_word[ST_FULL_BIT]  = full_done_r;
        rd_word[ST_WORD_BIT]  = pin_r.word_width_select;
        rd_word[ST_MODE_BIT]  = short_mode_r;
      end
      ADDR_RESULT:   rd_word[11:0] = result_r;
      ADDR_INT_STAT: rd_word[2:0]  = int_stat_r;
      ADDR_INT_MASK: rd_word[2:0]  = int_mask_r;
      default:       rd_word = 32'h0000_0000;
    endcase
    if (HADDR[31:8] != 24'h00_0000) begin
      rd_word = 32'h0000_0000;
    end
  end

  // zero-wait slave: data captured at the address phase
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      HRDATA    <= 32'h0000_0000;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      wr_pend_r <= addr_ok && HWRITE && (HADDR[31:8] == 24'h00_0000);
      if (addr_ok) begin
        wr_addr_r <= HADDR[7:0];
        HRDATA    <= HWRITE ? 32'h0000_0000 : rd_word;
      end
    end
  end

  // event and mask registers
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      int_stat_r <= INT_STAT_RST;
      int_mask_r <= INT_MASK_RST;
    end else begin
      int_stat_r <= sticky(int_stat_r, ev_clr, ev_set);
      if (wr_pend_r && wr_addr_r == ADDR_INT_MASK) begin
        int_mask_r <= HWDATA[2:0];
      end
    end
  end

  // interrupt line
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(int_stat_r & int_mask_r);
    end
  end

endmodule
`default_nettype wire

// >>> sim/adc_bus_control_props.sv
// assertion checker for the converter control pins
`timescale 1ns/1ps
`default_nettype none
module adc_bus_control_props (
  input wire logic        CLK_SYS,
  input wire logic        RESET,
  input wire logic        ENABLE,
  input wire logic        SELECT_N,
  input wire logic        READ_NOT_CONVERT,
  input wire logic        BYTE_OR_SHORT_SELECT,
  input wire logic        WORD_WIDTH_SELECT,
  input wire logic [11:0] DATA_OUT,
  input wire logic [11:0] DATA_OE,
  input wire logic        CONVERSION_STATUS,
  input wire logic        HRESP
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  logic [11:0] hi_cnt_r; // cycles spent busy so far
  // ====
  // busy length counter
  always_ff @(posedge CLK_SYS) begin
    if (RESET || !CONVERSION_STATUS) hi_cnt_r <= 12'h000;
    else hi_cnt_r <= hi_cnt_r + 12'h001;
  end
  // start strobe seen while idle
  sequence start_seq;
    $rose(ENABLE && !SELECT_N && !READ_NOT_CONVERT) && !CONVERSION_STATUS;
  endsequence
  chk_status_rise: assert property (start_seq |-> ##3 CONVERSION_STATUS)
    else $error("status did not rise after start");
  chk_rise_cause: assert property ($rose(CONVERSION_STATUS) |->
    $past(ENABLE, 3) && !$past(SELECT_N, 3) && !$past(READ_NOT_CONVERT, 3))
    else $error("status rose without a start");
  chk_cycle_len: assert property ($fell(CONVERSION_STATUS) |->
    (hi_cnt_r >= 12'h7CB && hi_cnt_r <= 12'h7D5) || (hi_cnt_r >= 12'hBB3 && hi_cnt_r <= 12'hBBD))
    else $error("conversion length wrong");
  chk_oe_busy: assert property (CONVERSION_STATUS |-> DATA_OE == 12'h000)
    else $error("outputs enabled while busy");
  chk_oe_cause: assert property (DATA_OE != 12'h000 |->
    $past(ENABLE, 3) && !$past(SELECT_N, 3) && $past(READ_NOT_CONVERT, 3))
    else $error("outputs enabled without a read");
  chk_word_oe: assert property (DATA_OE != 12'h000 && WORD_WIDTH_SELECT |-> DATA_OE == 12'hFFF)
    else $error("word read not twelve bits");
  chk_byte_oe: assert property (DATA_OE != 12'h000 && !WORD_WIDTH_SELECT |-> DATA_OE == 12'hFF0)
    else $error("byte read lanes wrong");
  // byte lanes: bits below the byte are zero, low byte adds four trailing zeros
  chk_low_zero: assert property (DATA_OE == 12'hFF0 |->
    DATA_OUT[3:0] == 4'h0 && (!$past(BYTE_OR_SHORT_SELECT, 3) || DATA_OUT[7:4] == 4'h0))
    else $error("low byte trailing bits set");
  chk_resp_okay: assert property (HRESP == 1'b0)
    else $error("bus response not okay");
endmodule
bind adc_bus_control adc_bus_control_props adc_bus_control_props_i (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .ENABLE(ENABLE), .SELECT_N(SELECT_N),
  .READ_NOT_CONVERT(READ_NOT_CONVERT), .BYTE_OR_SHORT_SELECT(BYTE_OR_SHORT_SELECT),
  .WORD_WIDTH_SELECT(WORD_WIDTH_SELECT),
  .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .CONVERSION_STATUS(CONVERSION_STATUS), .HRESP(HRESP));
`default_nettype wire

// >>> sim/host_pins_model.sv
// host bus model driving the converter control pins
`timescale 1ns/1ps
`default_nettype none
module host_pins_model (
  input  wire logic clk,
  output var  logic en,
  output var  logic sel_n,
  output var  logic rnc,
  output var  logic bsel
);
  // ====
  // idle bus at time zero
  initial begin
    en = 1'b0;
    sel_n = 1'b1;
    rnc = 1'b1;
    bsel = 1'b0;
  end
  // convert start, level set before strobes, strobe on enable
  task start(input logic s, input logic sn);
    @(posedge clk); rnc <= 1'b0; bsel <= s;
    @(posedge clk); en <= 1'b1; sel_n <= sn;
    repeat (4) @(posedge clk);
    en <= 1'b0;
    sel_n <= 1'b1;
  endtask
  // read: byte select settles 150 ns before enable, held to the end
  task rd_on(input logic s);
    @(posedge clk); rnc <= 1'b1; bsel <= s;
    repeat (15) @(posedge clk); en <= 1'b1; sel_n <= 1'b0;
  endtask
  task rd_off;
    @(posedge clk); en <= 1'b0; sel_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import adc_ctrl_pkg::*;
;
  logic        clk, rst, wws, hsel, hwrite, hrdy, hresp, irq, sts, en, sel_n, rnc, bsel, cge;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [11:0] dout, doe, dac, ain;
  int          failures, compares, n;
  time         t0; // moment the busy level was first seen
  assign cge = (ain >= dac); // ideal comparator
  adc_bus_control adc_bus_control_i (.CLK_SYS(clk), .RESET(rst), .ENABLE(en), .SELECT_N(sel_n),
    .READ_NOT_CONVERT(rnc), .BYTE_OR_SHORT_SELECT(bsel), .WORD_WIDTH_SELECT(wws),
    .DATA_OUT(dout), .DATA_OE(doe), .CONVERSION_STATUS(sts), .COMP_GE(cge), .DAC_CODE(dac),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .IRQ(irq));
  host_pins_model host_pins_model_i (.clk(clk), .en(en), .sel_n(sel_n), .rnc(rnc), .bsel(bsel));
  // ====
  // helpers
  always #5 clk = ~clk;
  task close_out;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // single word transfer, waits on ready in both phases
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk); hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    @(posedge clk); while (hrdy !== 1'b1) @(posedge clk);
    htrans <= 2'h0; hwdata <= wd;
    @(posedge clk); while (hrdy !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task rd(input logic s, input logic [11:0] ed, input logic [11:0] eo);
    host_pins_model_i.rd_on(s); repeat (5) @(posedge clk);
    cmp({20'h0, dout}, {20'h0, ed});
    cmp({20'h0, doe}, {20'h0, eo});
    host_pins_model_i.rd_off; repeat (5) @(posedge clk);
  endtask
  // conversion with a blocked read and an ignored restart inside it
  task conv(input logic s, input int lo, input int hi);
    host_pins_model_i.start(s, 1'b0); n = 0;
    while (sts !== 1'b1 && n < 20) begin @(posedge clk); n++; end
    cmp({31'h0, sts}, 32'h1);
    t0 = $time;
    host_pins_model_i.rd_on(1'b0); repeat (5) @(posedge clk);
    cmp({20'h0, doe}, 32'h0);
    host_pins_model_i.rd_off; host_pins_model_i.start(!s, 1'b0);
    n = 0;
    while (sts === 1'b1 && n < 5000) begin @(posedge clk); n++; end
    // busy length in clocks, measured over the whole window
    n = int'(($time - t0) / CLK_PERIOD_NS);
    cmp({31'h0, n >= lo && n <= hi}, 32'h1);
  endtask
  // watchdog
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    close_out;
  end
  // ====
  // main sequence
  initial begin
    clk = 1'b0; rst = 1'b1; wws = 1'b1; hsel = 1'b0; htrans = 2'h0; haddr = 32'h0;
    hwrite = 1'b0; hwdata = 32'h0; ain = 12'hA5C; failures = 0; compares = 0;
    repeat (8) @(posedge clk); rst <= 1'b0;
    ahb(1'b0, 8'h10, 32'h0, rv); cmp(rv, 32'h0);
    ahb(1'b1, ADDR_INT_MASK, 32'h7, rv);
    host_pins_model_i.start(1'b0, 1'b1); repeat (10) @(posedge clk);
    cmp({31'h0, sts}, 32'h0);
    $display("test idle done");
    conv(1'b0, 2995, 3015);
    cmp({31'h0, irq}, 32'h1);
    ahb(1'b0, ADDR_INT_STAT, 32'h0, rv); cmp(rv, 32'h7);
    ahb(1'b1, ADDR_INT_STAT, 32'h7, rv);
    ahb(1'b0, ADDR_INT_STAT, 32'h0, rv); cmp(rv, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    ahb(1'b0, ADDR_STATUS, 32'h0, rv); cmp(rv, 32'hE);
    ahb(1'b0, ADDR_RESULT, 32'h0, rv); cmp(rv, 32'hA5C);
    rd(1'b0, 12'hA5C, 12'hFFF);
    rd(1'b1, 12'hA5C, 12'hFFF);
    wws <= 1'b0; repeat (4) @(posedge clk); // strap rewired only while idle
    rd(1'b0, 12'hA50, 12'hFF0);
    rd(1'b1, 12'hC00, 12'hFF0);
    $display("test full cycle done");
    ain <= 12'h3C7;
    conv(1'b1, 1995, 2015);
    ahb(1'b0, ADDR_RESULT, 32'h0, rv); cmp({24'h0, rv[11:4]}, 32'h3C);
    ahb(1'b0, ADDR_STATUS, 32'h0, rv); cmp({27'h0, rv[4:0]}, 32'h16);
    rd(1'b0, 12'h3C0, 12'hFF0);
    $display("test short cycle done");
    close_out;
  end
endmodule
`default_nettype wire
